// >>> lgia_checker_assertions.sv
// port checker for the link group interrupt aggregator
`timescale 1ns/10ps
module lgia_chk (
	// clock and reset
	input wire        sys_clk_i,
	input wire        rst_i,
	// host port and pin
	input wire [11:0] addr_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [15:0] wdata_i,
	input wire [15:0] rdata_o,
	input wire        irq_n_o,
	// link events
	input wire [15:0] frame_loss_i,
	input wire [15:0] cell_delineation_loss_i,
	input wire [15:0] cell_delineation_loss_end_i,
	input wire [15:0] control_cell_violation_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// link 3 event, a quiet cycle, then a read of its status
	sequence s_ev_rd(e);
		e ##1 !wr_i ##1 rd_i && !wr_i && addr_i == 12'h438;
	endsequence
	sequence s_men_off;
		wr_i && addr_i == 12'h433 && wdata_i == 16'h0000 ##1 !(wr_i && addr_i == 12'h433);
	endsequence
	a_hi_link_zero: assert property (rd_i && addr_i > 12'h435 && addr_i < 12'h445 |=> rdata_o[8:7] == 2'h0)
		else $error("link flag 8:7 set");
	a_en_top_zero: assert property (rd_i && addr_i > 12'h444 && addr_i < 12'h455 |=> rdata_o[15:12] == 4'h0)
		else $error("enable 15:12 set");
	a_govf_top: assert property (rd_i && addr_i == 12'h457 |=> rdata_o[15:8] == 8'h00)
		else $error("group 15:8 set");
	a_frame_set: assert property (s_ev_rd(frame_loss_i[3]) |=> rdata_o[2])
		else $error("frame flag missing");
	a_cell_set: assert property (s_ev_rd(cell_delineation_loss_i[3]) |=> rdata_o[1])
		else $error("cell flag missing");
	a_cell_end: assert property (s_ev_rd(cell_delineation_loss_end_i[3]) |=> rdata_o[9])
		else $error("cell end flag missing");
	a_viol_set: assert property (s_ev_rd(control_cell_violation_i[3]) |=> rdata_o[4])
		else $error("violation flag missing");
	a_mask_off: assert property (s_men_off |=> irq_n_o)
		else $error("pin low when masked");
endmodule // lgia_chk
bind lgia_top lgia_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
	.rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_n_o(irq_n_o), .frame_loss_i(frame_loss_i),
	.cell_delineation_loss_i(cell_delineation_loss_i), .cell_delineation_loss_end_i(cell_delineation_loss_end_i),
	.control_cell_violation_i(control_cell_violation_i));

// >>> lgia_defs.vh
// constants and register map of the link group interrupt aggregator
`ifndef LGIA_DEFS_VH
`define LGIA_DEFS_VH

`define LGIA_ADDR_W        12
`define LGIA_NUM_LINKS     16
`define LGIA_NUM_GROUPS    8
// status registers, one per link
`define LGIA_STAT_BASE     12'h435
// enable registers, one per link
`define LGIA_EN_BASE       12'h445
`define LGIA_MSTAT_ADDR    12'h455
`define LGIA_MEN_ADDR      12'h433
`define LGIA_GOVF_ADDR     12'h457
// status bit positions
`define LGIA_B_CNTOVF      0
`define LGIA_B_GOVF        8
`define LGIA_B_TXRDY       7
`define LGIA_W1C_MASK      12'he7e
`define LGIA_LINK0_MASK    12'h180
`define LGIA_FLAG_W        12
`define LGIA_RST_16        16'h0000

`endif

// >>> lgia_link_flags.v
// per-link status flags and enable register
`timescale 1ns/10ps

module lgia_link_flags #(
	parameter IS_LINK0 = 0
) (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        rst_i,
	// event inputs, one-cycle pulses or levels
	input  wire [11:0] evt_i,
	input  wire        cnt_ovf_i,
	input  wire        grp_ovf_any_i,
	// register writes
	input  wire        stat_wr_i,
	input  wire        en_wr_i,
	input  wire [15:0] wdata_i,
	// results
	output wire [15:0] stat_o,
	output wire [15:0] en_o,
	output wire        req_o
);

`include "lgia_defs.vh"

	reg  [11:0] flag_ff;
	reg  [11:0] en_ff;
	wire [11:0] nxt_flag;
	wire [11:0] keep_mask;
	wire [11:0] view;

	// bits 8 and 7 exist on link 0 only; bit 8 is live there, so only bit 7 is stored
	assign keep_mask = (IS_LINK0 != 0) ? (`LGIA_W1C_MASK | (12'h001 << `LGIA_B_TXRDY)) : `LGIA_W1C_MASK;

	// write zero clears, a new event wins over the clear
	assign nxt_flag = ((stat_wr_i ? (flag_ff & wdata_i[11:0]) : flag_ff) | evt_i) & keep_mask;

	// flag storage and enable storage
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			flag_ff <= 12'h000;
			en_ff   <= 12'h000;
		end else begin
			flag_ff <= nxt_flag;
			if (en_wr_i) begin
				en_ff <= wdata_i[11:0];
			end
		end
	end

	// live sources: counter overflow and group overflow summary
	assign view = {flag_ff[11:9],
	               (IS_LINK0 != 0) & grp_ovf_any_i,
	               flag_ff[7:1],
	               cnt_ovf_i};

	assign stat_o = {4'h0, view};
	assign en_o   = {4'h0, en_ff};
	assign req_o  = |(view & en_ff);

endmodule // lgia_link_flags

// >>> lgia_top.v
// link group interrupt aggregator: status, enables, master summary, irq pin
`timescale 1ns/10ps

module lgia_top (
	// clock and reset
	input  wire         sys_clk_i,
	input  wire         rst_i,
	// host register port
	input  wire [11:0]  addr_i,
	input  wire         wr_i,
	input  wire         rd_i,
	input  wire [15:0]  wdata_i,
	output wire [15:0]  rdata_o,
	// per-link events, one-cycle pulses
	input  wire [15:0]  delay_sync_loss_end_i,
	input  wire [15:0]  frame_loss_end_i,
	input  wire [15:0]  cell_delineation_loss_end_i,
	input  wire [15:0]  pre_ram_ovf_i,
	input  wire [15:0]  control_cell_change_i,
	input  wire [15:0]  control_cell_violation_i,
	input  wire [15:0]  delay_sync_loss_i,
	input  wire [15:0]  frame_loss_i,
	input  wire [15:0]  cell_delineation_loss_i,
	// per-link counter overflow, level held until counters serviced
	input  wire [15:0]  link_cnt_ovf_i,
	// group events
	input  wire [7:0]   tx_cell_ready_rise_i,
	input  wire [7:0]   group_frame_pulse_i,
	input  wire [7:0]   group_ovf_evt_i,
	// interrupt pin, active low
	output wire         irq_n_o
);

`include "lgia_defs.vh"

	// read source codes for the register read mux
	localparam RSEL_NONE  = 3'h0;
	localparam RSEL_STAT  = 3'h1;
	localparam RSEL_EN    = 3'h2;
	localparam RSEL_MSTAT = 3'h3;
	localparam RSEL_MEN   = 3'h4;
	localparam RSEL_GOVF  = 3'h5;

	// registers
	reg  [15:0]  rdata_ff;
	reg          irq_n_ff;
	reg  [15:0]  men_ff;
	reg  [7:0]   govf_ff;

	// next-state and mux values
	reg  [15:0]  nxt_rdata;
	reg  [15:0]  nxt_men;
	reg  [7:0]   nxt_govf;
	reg  [15:0]  stat_word;
	reg  [15:0]  en_word;
	reg  [2:0]   rd_sel;
	reg  [15:0]  stat_wr_vec;
	reg  [15:0]  en_wr_vec;

	// address decode
	wire [11:0]  stat_off;
	wire [11:0]  en_off;
	wire         hit_stat;
	wire         hit_en;
	wire         hit_mstat;
	wire         hit_men;
	wire         hit_govf;
	wire [3:0]   link_sel;
	wire         men_wr;
	wire         govf_wr;
	wire [7:0]   govf_clr;

	// per-link results and interrupt summary
	wire [255:0] stat_bus;
	wire [255:0] en_bus;
	wire [15:0]  link_req;
	wire [15:0]  req_masked;
	wire         irq_req_any;

	// group events
	wire [7:0]   grp_txrdy;
	wire         txrdy_evt;
	wire         grp_ovf_any;

	////////////////////////////////////////////////////////////////////////
	// address decode: offsets into the two banks of sixteen link registers
	assign stat_off  = addr_i - `LGIA_STAT_BASE;
	assign en_off    = addr_i - `LGIA_EN_BASE;

	// bank hits; an address below a base wraps to a large offset and misses
	assign hit_stat  = (stat_off < 12'h010);
	assign hit_en    = (en_off < 12'h010);

	// single registers
	assign hit_mstat = (addr_i == `LGIA_MSTAT_ADDR);
	assign hit_men   = (addr_i == `LGIA_MEN_ADDR);
	assign hit_govf  = (addr_i == `LGIA_GOVF_ADDR);

	// link number inside whichever bank was hit
	assign link_sel  = hit_stat ? stat_off[3:0] : en_off[3:0];

	// write strobes of the single registers; master status takes none
	assign men_wr    = wr_i & hit_men;
	assign govf_wr   = wr_i & hit_govf;

	// one write strobe per link register, one-hot or all zero
	always @* begin
		stat_wr_vec = 16'h0000;
		en_wr_vec   = 16'h0000;
		if (wr_i && hit_stat) begin
			stat_wr_vec[link_sel] = 1'b1;
		end
		if (wr_i && hit_en) begin
			en_wr_vec[link_sel] = 1'b1;
		end
	end

	// read source, coded once per address
	always @* begin
		rd_sel = RSEL_NONE;
		if (hit_stat) begin
			rd_sel = RSEL_STAT;
		end else if (hit_en) begin
			rd_sel = RSEL_EN;
		end else if (hit_mstat) begin
			rd_sel = RSEL_MSTAT;
		end else if (hit_men) begin
			rd_sel = RSEL_MEN;
		end else if (hit_govf) begin
			rd_sel = RSEL_GOVF;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// group events: any ready return or frame pulse feeds link 0 bit 7
	assign grp_txrdy   = tx_cell_ready_rise_i | group_frame_pulse_i;
	assign txrdy_evt   = |grp_txrdy;

	// any pending group overflow shows live in link 0 bit 8
	assign grp_ovf_any = |govf_ff;

	////////////////////////////////////////////////////////////////////////
	// per-link flag blocks
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_link
			wire [11:0] evt;
			assign evt = {delay_sync_loss_end_i[g], frame_loss_end_i[g],
			              cell_delineation_loss_end_i[g], 1'b0,
			              (g == 0) & txrdy_evt, pre_ram_ovf_i[g],
			              control_cell_change_i[g], control_cell_violation_i[g],
			              delay_sync_loss_i[g], frame_loss_i[g],
			              cell_delineation_loss_i[g], 1'b0};
			lgia_link_flags #(
				.IS_LINK0 (g == 0)
			) u_flags (
				.sys_clk_i     (sys_clk_i),
				.rst_i         (rst_i),
				.evt_i         (evt),
				.cnt_ovf_i     (link_cnt_ovf_i[g]),
				.grp_ovf_any_i (grp_ovf_any),
				.stat_wr_i     (stat_wr_vec[g]),
				.en_wr_i       (en_wr_vec[g]),
				.wdata_i       (wdata_i),
				.stat_o        (stat_bus[g*16 +: 16]),
				.en_o          (en_bus[g*16 +: 16]),
				.req_o         (link_req[g])
			);

			// a link pulls the pin only while its master enable bit is set
			assign req_masked[g] = link_req[g] & men_ff[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// master enable: plain read/write, one bit per link
	always @* begin
		nxt_men = men_ff;
		if (men_wr) begin
			nxt_men = wdata_i;
		end
	end

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			men_ff <= `LGIA_RST_16;
		end else begin
			men_ff <= nxt_men;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// group overflow: writing zero to a bit clears it
	assign govf_clr = govf_wr ? ~wdata_i[7:0] : 8'h00;

	// a new overflow in the same cycle as the clear wins
	always @* begin
		nxt_govf = (govf_ff & ~govf_clr) | group_ovf_evt_i;
	end

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			govf_ff <= 8'h00;
		end else begin
			govf_ff <= nxt_govf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status word of the addressed link
	always @* begin
		case (link_sel)
			4'h0: stat_word = stat_bus[15:0];
			4'h1: stat_word = stat_bus[31:16];
			4'h2: stat_word = stat_bus[47:32];
			4'h3: stat_word = stat_bus[63:48];
			4'h4: stat_word = stat_bus[79:64];
			4'h5: stat_word = stat_bus[95:80];
			4'h6: stat_word = stat_bus[111:96];
			4'h7: stat_word = stat_bus[127:112];
			4'h8: stat_word = stat_bus[143:128];
			4'h9: stat_word = stat_bus[159:144];
			4'ha: stat_word = stat_bus[175:160];
			4'hb: stat_word = stat_bus[191:176];
			4'hc: stat_word = stat_bus[207:192];
			4'hd: stat_word = stat_bus[223:208];
			4'he: stat_word = stat_bus[239:224];
			4'hf: stat_word = stat_bus[255:240];
			default: stat_word = 16'h0000;
		endcase
	end

	// enable word of the addressed link
	always @* begin
		case (link_sel)
			4'h0: en_word = en_bus[15:0];
			4'h1: en_word = en_bus[31:16];
			4'h2: en_word = en_bus[47:32];
			4'h3: en_word = en_bus[63:48];
			4'h4: en_word = en_bus[79:64];
			4'h5: en_word = en_bus[95:80];
			4'h6: en_word = en_bus[111:96];
			4'h7: en_word = en_bus[127:112];
			4'h8: en_word = en_bus[143:128];
			4'h9: en_word = en_bus[159:144];
			4'ha: en_word = en_bus[175:160];
			4'hb: en_word = en_bus[191:176];
			4'hc: en_word = en_bus[207:192];
			4'hd: en_word = en_bus[223:208];
			4'he: en_word = en_bus[239:224];
			4'hf: en_word = en_bus[255:240];
			default: en_word = 16'h0000;
		endcase
	end

	// read mux; master status is read only, unmapped addresses read zero
	always @* begin
		case (rd_sel)
			RSEL_STAT: begin
				nxt_rdata = stat_word;
			end
			RSEL_EN: begin
				nxt_rdata = en_word;
			end
			RSEL_MSTAT: begin
				nxt_rdata = link_req;
			end
			RSEL_MEN: begin
				nxt_rdata = men_ff;
			end
			RSEL_GOVF: begin
				nxt_rdata = {8'h00, govf_ff};
			end
			default: begin
				nxt_rdata = 16'h0000;
			end
		endcase
	end

	// read data holds until the next read strobe
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_ff <= `LGIA_RST_16;
		end else if (rd_i) begin
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pin: unlatched summary, one flop behind, idle high
	assign irq_req_any = |req_masked;

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= ~irq_req_any;
		end
	end

	assign rdata_o = rdata_ff;
	assign irq_n_o = irq_n_ff;

endmodule // lgia_top

// >>> tb_top.sv
// self-checking bench for the link group interrupt aggregator
`timescale 1ns/10ps
module tb_top;
	reg         sys_clk_i  = 1'b0;
	reg         rst_i      = 1'b1;
	reg  [11:0] addr_i     = 12'h000;
	reg         wr_i       = 1'b0;
	reg         rd_i       = 1'b0;
	reg  [15:0] wdata_i    = 16'h0000;
	reg  [15:0] ev [0:11];
	wire [15:0] rdata_o;
	wire        irq_n_o;
	integer     n_mismatch = 0;
	integer     cmp_count  = 0;
	integer     b;
	always #2.5 sys_clk_i = ~sys_clk_i;
	// events by status bit; ev[7] and ev[8] carry the group events
	lgia_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .delay_sync_loss_end_i(ev[11]), .frame_loss_end_i(ev[10]),
		.cell_delineation_loss_end_i(ev[9]), .pre_ram_ovf_i(ev[6]), .control_cell_change_i(ev[5]),
		.control_cell_violation_i(ev[4]), .delay_sync_loss_i(ev[3]), .frame_loss_i(ev[2]),
		.cell_delineation_loss_i(ev[1]), .link_cnt_ovf_i(ev[0]), .tx_cell_ready_rise_i(ev[7][7:0]),
		.group_frame_pulse_i(ev[8][7:0]), .group_ovf_evt_i(ev[8][15:8]), .irq_n_o(irq_n_o));
	////////////////////////////////////////////////////////////////
	task chk(input string n, input [15:0] e, input [15:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (e !== g) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %s %h expected %h seen %h", n, addr_i, e, g);
			end
		end
	endtask
	task wr(input [11:0] a, input [15:0] d);
		begin
			@(posedge sys_clk_i);
			addr_i  <= a;
			wdata_i <= d;
			wr_i    <= 1'b1;
			@(posedge sys_clk_i);
			wr_i <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, input [15:0] e);
		begin
			@(posedge sys_clk_i);
			addr_i <= a;
			rd_i   <= 1'b1;
			@(posedge sys_clk_i);
			rd_i <= 1'b0;
			#1 chk("reg", e, rdata_o);
		end
	endtask
	task pulse(input integer k, input [15:0] m);
		begin
			@(posedge sys_clk_i);
			ev[k] <= m;
			@(posedge sys_clk_i);
			ev[k] <= 16'h0000;
		end
	endtask
	task irq(input e);
		begin
			repeat (2) @(posedge sys_clk_i);
			#1 chk("irq", {15'h0000, e}, {15'h0000, irq_n_o});
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// hang guard
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
	initial begin
		for (b = 0; b < 12; b = b + 1)
			ev[b] = 16'h0000;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(12'h445, 16'h0000);
		rd(12'h455, 16'h0000);
		rd(12'h457, 16'h0000);
		irq(1'b1);
		$display("test reset done");
		// each sticky flag of link 3: set, clear by writing zero
		for (b = 1; b < 12; b = b + 1)
			if (b != 7 && b != 8) begin
				pulse(b, 16'h0008);
				rd(12'h438, 16'h0001 << b);
				wr(12'h438, 16'h0000);
				rd(12'h438, 16'h0000);
			end
		@(posedge sys_clk_i);
		ev[0] <= 16'h0008;
		wr(12'h438, 16'h0000);
		rd(12'h438, 16'h0001);
		@(posedge sys_clk_i);
		ev[0] <= 16'h0000;
		rd(12'h438, 16'h0000);
		$display("test flags done");
		pulse(7, 16'h0004);
		rd(12'h435, 16'h0080);
		wr(12'h435, 16'h0000);
		pulse(8, 16'h0001);
		pulse(8, 16'h2000);
		rd(12'h457, 16'h0020);
		rd(12'h435, 16'h0180);
		rd(12'h436, 16'h0000);
		wr(12'h435, 16'h0000);
		rd(12'h435, 16'h0100);
		wr(12'h457, 16'h0000);
		rd(12'h435, 16'h0000);
		$display("test group done");
		wr(12'h448, 16'hffff);
		rd(12'h448, 16'h0fff);
		pulse(4, 16'h0008);
		rd(12'h455, 16'h0008);
		irq(1'b1);
		wr(12'h433, 16'h0008);
		irq(1'b0);
		rd(12'h433, 16'h0008);
		wr(12'h455, 16'h0000);
		rd(12'h455, 16'h0008);
		wr(12'h433, 16'h0000);
		irq(1'b1);
		wr(12'h433, 16'h0008);
		wr(12'h448, 16'h0000);
		rd(12'h455, 16'h0000);
		irq(1'b1);
		rd(12'h456, 16'h0000);
		$display("test irq done");
		finish_test;
	end
endmodule // tb_top
